// File: core/dvd_params.svh
`ifndef DVD_PARAMS_SVH
`define DVD_PARAMS_SVH
// Byte addresses: printed subaddresses are indices, address is four times index
`define DVD_IDX_CFG 4'h0
`define DVD_IDX_ON 4'h4
`define DVD_IDX_OFF 4'h5
`define DVD_IDX_LOW 4'h6
`define DVD_IDX_HIGH 4'h7
`define DVD_IDX_STR 4'h8
`define DVD_IDX_STAT 4'h9
`define DVD_IDX_CLR 4'ha
`define DVD_IDX_IEN 4'hb
`define DVD_IDX_CTL 4'hc
`define DVD_RST_CFG 16'h0000
`define DVD_RST_ON 16'hfebf
`define DVD_RST_OFF 16'hf37f
`define DVD_RST_LOW 12'h000
`define DVD_RST_HIGH 12'h001
`define DVD_RST_STR 6'h3f
`define DVD_BIT_SLICER 15
`define DVD_BIT_MODE_A 5
`define DVD_BIT_MODE_B 6
`define DVD_POLL_TOP 16'hffff
`define DVD_DIV_LAST 2'h3
`define DVD_PERIODS 2'h3
`define DVD_SETTLE_US 2600
`define DVD_CLK_KHZ 10000
`endif

// File: core/dvd_pkg.sv
package dvd_pkg;
  typedef enum logic [1:0] {
    DVD_IDLE = 2'b00,
    DVD_SETTLE = 2'b01,
    DVD_ACTIVE = 2'b10,
    DVD_HOLD = 2'b11
  } dvd_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dvd_apb_req_s;
  typedef struct packed {
    logic pos_peak;
    logic neg_peak;
  } dvd_peak_s;
endpackage : dvd_pkg

// File: core/dvd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvd_params.svh"
module dvd_top
  import dvd_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`DVD_SETTLE_US * `DVD_CLK_KHZ) / 1000
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_on,
  input wire logic i_data,
  input wire logic i_rc_osc,
  input wire logic [5:0] i_strength,
  input wire logic i_pos_peak,
  input wire logic i_neg_peak,
  output logic o_slicer_peak,
  output logic o_peak_enable,
  output logic o_pos_peak,
  output logic o_neg_peak,
  output logic o_rx_enable,
  output logic o_detect_wake_out,
  output logic o_data_valid,
  output logic o_irq
);
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] device_configuration, poll_on_duration, poll_off_duration;
  logic [11:0] rate_window_low_limit, rate_window_high_limit;
  logic [5:0] signal_strength_limit;
  logic [1:0] status, irq_enable;
  logic poll_enable;
  logic [1:0] ev;
  dvd_apb_req_s req;
  logic wr, rd;
  logic [3:0] idx;
  logic mapped;
  assign req = '{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata};
  assign idx = req.paddr[5:2];
  assign mapped = (req.paddr[7:6] == 2'h0) && (req.paddr[1:0] == 2'h0) &&
                  (idx <= `DVD_IDX_CTL) && (idx != 4'h1) && (idx != 4'h2) && (idx != 4'h3);
  assign wr = req.psel && req.penable && req.pwrite && mapped;
  assign rd = req.psel && req.penable && !req.pwrite;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      device_configuration <= `DVD_RST_CFG;
      poll_on_duration <= `DVD_RST_ON;
      poll_off_duration <= `DVD_RST_OFF;
      rate_window_low_limit <= `DVD_RST_LOW;
      rate_window_high_limit <= `DVD_RST_HIGH;
      signal_strength_limit <= `DVD_RST_STR;
      irq_enable <= 2'h0;
      poll_enable <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        `DVD_IDX_CFG: device_configuration <= merge16(device_configuration, req.pwdata, i_pstrb);
        `DVD_IDX_ON: poll_on_duration <= merge16(poll_on_duration, req.pwdata, i_pstrb);
        `DVD_IDX_OFF: poll_off_duration <= merge16(poll_off_duration, req.pwdata, i_pstrb);
        `DVD_IDX_LOW: rate_window_low_limit <=
          12'(merge16({4'h0, rate_window_low_limit}, req.pwdata, i_pstrb));
        `DVD_IDX_HIGH: rate_window_high_limit <=
          12'(merge16({4'h0, rate_window_high_limit}, req.pwdata, i_pstrb));
        `DVD_IDX_STR: if (i_pstrb[0]) signal_strength_limit <= req.pwdata[5:0];
        `DVD_IDX_IEN: if (i_pstrb[0]) irq_enable <= req.pwdata[1:0];
        `DVD_IDX_CTL: if (i_pstrb[0]) poll_enable <= req.pwdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      // Zero-wait answer would need combinational outputs; one wait state instead
      o_pready <= req.psel && req.penable && !o_pready;
      o_pslverr <= req.psel && req.penable && !o_pready && !mapped;
      o_prdata <= 32'h0000_0000;
      if (rd && mapped && !o_pready) begin
        unique case (idx)
          `DVD_IDX_CFG: o_prdata <= {16'h0000, device_configuration};
          `DVD_IDX_ON: o_prdata <= {16'h0000, poll_on_duration};
          `DVD_IDX_OFF: o_prdata <= {16'h0000, poll_off_duration};
          `DVD_IDX_LOW: o_prdata <= {20'h00000, rate_window_low_limit};
          `DVD_IDX_HIGH: o_prdata <= {20'h00000, rate_window_high_limit};
          `DVD_IDX_STR: o_prdata <= {26'h0000000, signal_strength_limit};
          `DVD_IDX_STAT: o_prdata <= {30'h00000000, status};
          `DVD_IDX_IEN: o_prdata <= {30'h00000000, irq_enable};
          `DVD_IDX_CTL: o_prdata <= {31'h00000000, poll_enable};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Status clear takes effect once: only in the access cycle before pready
  logic wr_now;
  assign wr_now = wr && !o_pready;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] data_s, rc_s, rx_s;
  logic [5:0] str_m, str_s;
  dvd_peak_s peak_m, peak_s;
  logic data_d, rc_d;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      data_s <= 2'h0;
      rc_s <= 2'h0;
      rx_s <= 2'h0;
      str_m <= 6'h00;
      str_s <= 6'h00;
      peak_m <= '0;
      peak_s <= '0;
      data_d <= 1'b0;
      rc_d <= 1'b0;
    end else begin
      data_s <= {data_s[0], i_data};
      rc_s <= {rc_s[0], i_rc_osc};
      rx_s <= {rx_s[0], i_rx_on};
      str_m <= i_strength;
      str_s <= str_m;
      peak_m <= '{i_pos_peak, i_neg_peak};
      peak_s <= peak_m;
      data_d <= data_s[1];
      rc_d <= rc_s[1];
    end
  end
  logic rise, fall, rc_tick, rx_on;
  assign rise = data_s[1] && !data_d;
  assign fall = !data_s[1] && data_d;
  assign rc_tick = rc_s[1] && !rc_d;

  // ****************************************
  // Self-polling on/off timer
  // ****************************************
  logic poll_phase_on;
  logic [15:0] poll_cnt;
  logic wake_req;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !poll_enable) begin
      poll_phase_on <= 1'b1;
      poll_cnt <= poll_on_duration;
    end else if (rc_tick) begin
      if (poll_cnt == `DVD_POLL_TOP) begin
        poll_phase_on <= !poll_phase_on;
        poll_cnt <= poll_phase_on ? poll_off_duration : poll_on_duration;
      end else begin
        poll_cnt <= poll_cnt + 16'h0001;
      end
    end
  end
  // Receive is on from the pin, or with polling enabled only during the polling on phase
  assign rx_on = poll_enable ? poll_phase_on : rx_s[1];

  // ****************************************
  // Sequencer
  // ****************************************
  dvd_state_e state, next_state;
  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt;
  logic win_done, result_ok, single_shot;
  assign single_shot = device_configuration[`DVD_BIT_MODE_A] &&
                       !device_configuration[`DVD_BIT_MODE_B];
  always_comb begin
    next_state = state;
    unique case (state)
      DVD_IDLE: if (rx_on) next_state = DVD_SETTLE;
      DVD_SETTLE: if (!rx_on) next_state = DVD_IDLE;
        else if (settle_cnt == ($bits(settle_cnt))'(SETTLE_CYCLES - 1)) next_state = DVD_ACTIVE;
      DVD_ACTIVE: if (!rx_on) next_state = DVD_IDLE;
        else if (single_shot && win_done) next_state = DVD_HOLD;
      DVD_HOLD: if (!rx_on) next_state = DVD_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= DVD_IDLE;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      settle_cnt <= (state == DVD_SETTLE) ? settle_cnt + 1'b1 : '0;
    end
  end
  logic detect_en;
  assign detect_en = (state == DVD_ACTIVE);

  // ****************************************
  // Window counter
  // ****************************************
  logic [1:0] div;
  logic [12:0] high_cnt;
  logic [1:0] periods;
  logic rate_hit, rate_ok, win_inactive, str_inactive;
  // High time is only checked at the fall once its rising edge was seen inside the active phase
  logic armed;
  assign win_inactive = (rate_window_low_limit == `DVD_RST_LOW) &&
                        (rate_window_high_limit == `DVD_RST_HIGH);
  assign str_inactive = (signal_strength_limit == `DVD_RST_STR);
  function automatic logic in_win(input logic [12:0] c, input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_win = (c >= {1'b0, lo}) && (c <= {1'b0, hi});
  endfunction : in_win
  assign rate_hit = in_win(high_cnt, rate_window_low_limit, rate_window_high_limit) ||
                    in_win(high_cnt, {rate_window_low_limit[10:0], 1'b0},
                           {rate_window_high_limit[10:0], 1'b0});
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !detect_en) begin
      div <= 2'h0;
      high_cnt <= 13'h0000;
      periods <= 2'h0;
      rate_ok <= 1'b1;
      win_done <= 1'b0;
      armed <= 1'b0;
    end else begin
      win_done <= 1'b0;
      div <= div + 2'h1;
      if (rise) armed <= 1'b1;
      if (rise) begin
        high_cnt <= 13'h0000;
      end else if (data_s[1] && div == `DVD_DIV_LAST && !(&high_cnt)) begin
        high_cnt <= high_cnt + 13'h0001;
      end
      if (fall && armed) begin
        rate_ok <= rate_ok && rate_hit;
        if (periods == `DVD_PERIODS - 2'h1) begin
          win_done <= 1'b1;
          periods <= 2'h0;
        end else begin
          periods <= periods + 2'h1;
        end
      end
      if (win_done) rate_ok <= 1'b1;
    end
  end

  // ****************************************
  // Strength latch and data valid
  // ****************************************
  logic str_ok, valid, win_done_d;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      str_ok <= 1'b0;
      valid <= 1'b0;
      win_done_d <= 1'b0;
      o_data_valid <= 1'b0;
    end else begin
      win_done_d <= win_done;
      if (win_done && !win_done_d) begin
        str_ok <= str_inactive || (str_s >= signal_strength_limit);
        valid <= (win_inactive || rate_ok);
      end
      if (state == DVD_IDLE) valid <= 1'b0;
      o_data_valid <= valid && str_ok && !(win_inactive && str_inactive);
    end
  end
  // ****************************************
  // Outputs and interrupt
  // ****************************************
  logic valid_q;
  assign ev = {win_done, o_data_valid && !valid_q};
  // Wake only on a fresh valid, so a standing valid cannot repeat the pulse
  assign wake_req = o_data_valid && !valid_q && rx_on;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_slicer_peak <= 1'b0;
      o_peak_enable <= 1'b0;
      o_pos_peak <= 1'b0;
      o_neg_peak <= 1'b1;
      o_rx_enable <= 1'b0;
      o_detect_wake_out <= 1'b0;
      valid_q <= 1'b0;
      status <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      o_slicer_peak <= device_configuration[`DVD_BIT_SLICER];
      o_peak_enable <= (state != DVD_IDLE) && (state != DVD_SETTLE);
      // Peak paths follow the enable only, never the slicer select
      o_pos_peak <= o_peak_enable ? peak_s.pos_peak : 1'b0;
      o_neg_peak <= o_peak_enable ? peak_s.neg_peak : 1'b1;
      o_rx_enable <= rx_on;
      valid_q <= o_data_valid;
      o_detect_wake_out <= wake_req && poll_phase_on;
      // Set wins over clear
      status <= (status & ~((wr_now && idx == `DVD_IDX_CLR) ? req.pwdata[1:0] : 2'h0)) | ev;
      o_irq <= |(status & irq_enable);
    end
  end
endmodule : dvd_top
`default_nettype wire

// File: verif/dvd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module dvd_asserts #(
  parameter int SETTLE_CYCLES = 26000
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_slicer_peak,
  input wire logic o_peak_enable,
  input wire logic o_pos_peak,
  input wire logic o_neg_peak,
  input wire logic o_rx_enable,
  input wire logic o_detect_wake_out,
  input wire logic o_data_valid,
  input wire logic o_irq
);
  int rx_run;
  // Saturates so a long receive period cannot wrap
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !o_rx_enable) begin
      rx_run <= 0;
    end else if (rx_run < SETTLE_CYCLES) begin
      rx_run <= rx_run + 1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  pready_a: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("bus answer late or held");
  decode_err_a: assert property (o_pready && i_paddr[7:6] != 2'h0 |-> o_pslverr)
    else $error("unmapped access not refused");
  slicer_sel_a: assert property (o_pready && !o_pslverr && i_pwrite && i_paddr == 8'h00
    |=> o_slicer_peak == $past(i_pwdata[15])) else $error("slicer source wrong");
  reset_out_a: assert property (@(posedge i_clk) disable iff (1'b0) !i_rst_b
    |=> !o_data_valid && o_neg_peak && !o_slicer_peak && !o_irq) else $error("reset outputs");
  peak_off_a: assert property (!o_peak_enable && !$past(o_peak_enable)
    |-> !o_pos_peak && o_neg_peak) else $error("disabled peak outputs");
  peak_late_a: assert property ($rose(o_peak_enable) |-> o_rx_enable && $past(o_rx_enable))
    else $error("peaks enabled early");
  wake_pulse_a: assert property (o_detect_wake_out |=> !o_detect_wake_out)
    else $error("wake pulse too long");
  wake_on_a: assert property (o_detect_wake_out |-> o_rx_enable || $past(o_rx_enable))
    else $error("wake outside on phase");
  settle_a: assert property ($rose(o_data_valid) |-> rx_run >= SETTLE_CYCLES)
    else $error("valid before settle");
  cover property ($rose(o_data_valid));
  cover property (o_detect_wake_out);
  cover property (o_pslverr);
endmodule : dvd_asserts
`default_nettype wire

// File: verif/dvd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host woken by the detect pulse
// ****
module dvd_host_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wake,
  output logic [7:0] o_wakes
);
  // Counts cycles seen high, so a stretched pulse shows as extra wakes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_wakes <= 8'h00;
    end else if (i_wake) begin
      o_wakes <= o_wakes + 8'h01;
    end
  end
endmodule : dvd_host_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvd_params.svh"
// ****
// Bench
// ****
module tb;
  localparam int SETTLE = 20;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic i_rx_on = 1'b0, i_data = 1'b0, i_rc_osc = 1'b0, i_pos_peak = 1'b1, i_neg_peak = 1'b0;
  logic [5:0] i_strength = 6'h28;
  logic o_pready, o_pslverr, o_slicer_peak, o_peak_enable, o_pos_peak, o_neg_peak, rerr;
  logic o_rx_enable, o_detect_wake_out, o_data_valid, o_irq, data_en = 1'b0;
  logic [7:0] wakes;
  int failures = 0, cmp_count = 0, dcnt = 0, rcnt = 0;
  logic [3:0] ri [6] = '{`DVD_IDX_CFG, `DVD_IDX_ON, `DVD_IDX_OFF, `DVD_IDX_LOW, `DVD_IDX_HIGH,
    `DVD_IDX_STR};
  logic [15:0] rv [6] = '{`DVD_RST_CFG, `DVD_RST_ON, `DVD_RST_OFF, 16'h0000, 16'h0001, 16'h003f};
  logic [15:0] wm [6] = '{16'hffff, 16'hffff, 16'hffff, 16'h0fff, 16'h0fff, 16'h003f};
  dvd_top #(.SETTLE_CYCLES(SETTLE)) dut (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb(4'hf), .o_prdata, .o_pready, .o_pslverr, .i_rx_on, .i_data,
    .i_rc_osc, .i_strength, .i_pos_peak, .i_neg_peak, .o_slicer_peak, .o_peak_enable,
    .o_pos_peak, .o_neg_peak, .o_rx_enable, .o_detect_wake_out, .o_data_valid, .o_irq);
  dvd_host_model host (.i_clk, .i_rst_b, .i_wake(o_detect_wake_out), .o_wakes(wakes));
  always #50 i_clk = ~i_clk;
  // Square data, high time 40 clocks (10 counts); oscillator edge every 8 clocks
  always @(posedge i_clk) begin
    dcnt <= (dcnt == 79) ? 0 : dcnt + 1;
    i_data <= data_en && dcnt < 40;
    rcnt <= rcnt + 1;
    i_rc_osc <= rcnt[2];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) chk(32'h1, 32'h0);
  endtask : apb
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    apb(1'b1, {2'h0, i, 2'h0}, {16'h0000, d});
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    apb(1'b0, {2'h0, i, 2'h0}, 32'h0);
    chk(rdat, {16'h0000, e});
  endtask : rd
  task automatic wait_valid(input logic v);
    int n;
    n = 0;
    while (o_data_valid !== v && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_data_valid, v);
  endtask : wait_valid
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (60000) @(posedge i_clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ri[k], rv[k]);
    apb(1'b0, 8'h04, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    chk(o_pos_peak, 1'b0);
    chk(o_neg_peak, 1'b1);
    i_rx_on <= 1'b1;
    data_en <= 1'b1;
    repeat (900) @(posedge i_clk);
    chk(o_data_valid, 1'b0);
    chk(o_pos_peak, 1'b1);
    chk(o_neg_peak, 1'b0);
    for (int k = 1; k < 6; k++) begin
      wr(ri[k], 16'ha5c3);
      rd(ri[k], 16'ha5c3 & wm[k]);
    end
    wr(`DVD_IDX_LOW, 16'h0008);
    wr(`DVD_IDX_HIGH, 16'h000c);
    wr(`DVD_IDX_STR, 16'h0014);
    wait_valid(1'b1);
    wr(`DVD_IDX_CFG, 16'h8000);
    @(posedge i_clk);
    chk(o_slicer_peak, 1'b1);
    chk(o_pos_peak, 1'b1);
    i_strength <= 6'h05;
    wait_valid(1'b0);
    i_strength <= 6'h28;
    wait_valid(1'b1);
    wr(`DVD_IDX_LOW, 16'h001e);
    wr(`DVD_IDX_HIGH, 16'h0028);
    wait_valid(1'b0);
    wr(`DVD_IDX_LOW, 16'h0004);
    wr(`DVD_IDX_HIGH, 16'h0006);
    wait_valid(1'b1);
    // Single shot: status cleared first so the interrupt proves a fresh evaluation
    i_rx_on <= 1'b0;
    wr(`DVD_IDX_CFG, 16'h0020);
    wr(`DVD_IDX_CLR, 16'h0003);
    i_rx_on <= 1'b1;
    wait_valid(1'b1);
    chk(o_irq, 1'b0);
    wr(`DVD_IDX_IEN, 16'h0001);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1'b1);
    apb(1'b0, {2'h0, `DVD_IDX_STAT, 2'h0}, 32'h0);
    chk(rdat[0], 1'b1);
    i_strength <= 6'h05;
    repeat (1000) @(posedge i_clk);
    chk(o_data_valid, 1'b1);
    wr(`DVD_IDX_CLR, 16'h0003);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1'b0);
    // Polling: on about 2000 clocks, off about 130
    i_strength <= 6'h28;
    wr(`DVD_IDX_CFG, 16'h0000);
    wr(`DVD_IDX_ON, 16'hff00);
    wr(`DVD_IDX_OFF, 16'hfff0);
    wr(`DVD_IDX_CTL, 16'h0001);
    repeat (7000) @(posedge i_clk);
    chk(wakes != 8'h00, 1'b1);
    complete_run();
  end
endmodule : tb
bind dvd_top dvd_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.i_clk, .i_rst_b, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_slicer_peak,
  .o_peak_enable, .o_pos_peak, .o_neg_peak, .o_rx_enable, .o_detect_wake_out, .o_data_valid,
  .o_irq);
`default_nettype wire
